// ---- logic/mlp_lpi_ctrl.sv ----
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "mlp_defines.svh"
module mlp_lpi_ctrl
    import mlp_pkg::*;
#(
    parameter int TW_WIDTH = 16,
    parameter int LS_WIDTH = 10
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic mac_tx_en,
    input wire logic mac_tx_er,
    input wire logic [3:0] mac_txd,
    output logic mac_tx_hold,
    input wire logic rx_clk,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] rxd,
    output logic tx_en,
    output logic tx_er,
    output logic [3:0] txd,
    output logic irq,
    output logic lowpower_irq_out
);
    if (TW_WIDTH != 16 || LS_WIDTH != 10) begin : g_bad_width
        $error("mlp_lpi_ctrl: timer widths must be 16 and 10");
    end

    // Receive pins pass two flops; the receive clock is only sampled
    logic [6:0] rx_sync;
    mlp_sync2 #(.WIDTH(7)) u_rx_sync (
        .clock(clock),
        .srst(srst),
        .din({rx_clk, rx_dv, rx_er, rxd}),
        .dout(rx_sync)
    );
    logic rxc_s, rxc_q;
    logic rx_pat;
    assign rxc_s = rx_sync[6];
    assign rx_pat = rx_sync[5:4] == 2'b01 && rx_sync[3:0] == `MLP_LPI_CODE;
    logic rxc_rise;
    assign rxc_rise = rxc_s && !rxc_q;

    // Registers
    logic tx_lowpower_enable, phy_link_status, tx_lowpower_auto;
    logic full_duplex, mii_mode;
    logic [TW_WIDTH-1:0] wake_time_value;
    logic [LS_WIDTH-1:0] ls_limit;
    logic [3:0] flags;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic next_enable, next_link, next_auto, next_fd, next_mii;
    logic [TW_WIDTH-1:0] next_twt;
    logic [LS_WIDTH-1:0] next_ls_limit;
    logic [3:0] next_flags;

    // Block state
    mlp_tx_state_t tx_state, next_tx_state;
    logic rx_lpi, next_rx_lpi;
    logic [4:0] us_div, next_us_div;
    logic [9:0] ms_div, next_ms_div;
    logic [LS_WIDTH-1:0] link_up_timer, next_link_up_timer;
    logic [TW_WIDTH-1:0] wake_timer, next_wake_timer;
    logic us_tick, ms_tick;
    logic next_tx_en, next_tx_er;
    logic [3:0] next_txd;
    logic next_lp_irq, next_rxc_q;
    logic [3:0] ev;
    logic csr_rd;
    logic link_ok, allowed;

    assign us_tick = us_div == 5'(`MLP_US_CYCLES - 1);
    assign ms_tick = us_tick && ms_div == 10'(`MLP_MS_US - 1);
    assign link_ok = phy_link_status && link_up_timer >= ls_limit;
    assign allowed = full_duplex && mii_mode;

    always_comb begin
        next_tx_state = tx_state;
        next_wake_timer = wake_timer;
        next_link_up_timer = link_up_timer;
        next_us_div = us_tick ? 5'h0 : us_div + 5'h1;
        next_ms_div = us_div == 5'(`MLP_US_CYCLES - 1)
            ? (ms_tick ? 10'h0 : ms_div + 10'h1) : ms_div;
        ev = 4'h0;
        if (!phy_link_status) begin
            next_link_up_timer = '0;
            // Dividers rest while the link is down so the first millisecond is whole
            next_us_div = '0;
            next_ms_div = '0;
        end else if (ms_tick && !link_ok) begin
            next_link_up_timer = link_up_timer + 1'b1;
        end
        case (tx_state)
            mlp_tx_norm: begin
                // Entry waits for the frame in flight to end
                if (tx_lowpower_enable && allowed && link_ok && !mac_tx_en) begin
                    next_tx_state = mlp_tx_lpi;
                    ev[`MLP_BIT_TX_ENTRY] = 1'b1;
                end
            end
            mlp_tx_lpi: begin
                if (!tx_lowpower_enable || !allowed || !phy_link_status) begin
                    next_tx_state = mlp_tx_wake;
                    next_wake_timer = '0;
                    // Whole first wake microsecond; the saturated link timer loses nothing
                    next_us_div = '0;
                    ev[`MLP_BIT_TX_EXIT] = 1'b1;
                end
            end
            mlp_tx_wake: begin
                if (!phy_link_status || wake_timer >= wake_time_value) begin
                    next_tx_state = mlp_tx_norm;
                end else if (us_tick) begin
                    next_wake_timer = wake_timer + 1'b1;
                end
            end
            default: next_tx_state = mlp_tx_norm;
        endcase
        // Receive side follows the sampled pattern; a halted clock just freezes it
        next_rx_lpi = rx_pat;
        next_rxc_q = rxc_s;
        if (rx_pat && !rx_lpi) begin
            ev[`MLP_BIT_RX_ENTRY] = 1'b1;
        end
        if (!rx_pat && rx_lpi) begin
            ev[`MLP_BIT_RX_EXIT] = 1'b1;
        end
        // Receive-exit pulse is held until the next receive clock rise
        next_lp_irq = lowpower_irq_out;
        if (ev[`MLP_BIT_RX_EXIT]) begin
            next_lp_irq = 1'b1;
        end else if (rxc_rise) begin
            next_lp_irq = 1'b0;
        end
        // Line drive
        if (tx_state == mlp_tx_lpi) begin
            next_tx_en = 1'b0;
            next_tx_er = 1'b1;
            next_txd = `MLP_LPI_CODE;
        end else if (tx_state == mlp_tx_wake) begin
            next_tx_en = 1'b0;
            next_tx_er = 1'b0;
            next_txd = `MLP_IDLE_CODE;
        end else begin
            next_tx_en = mac_tx_en;
            next_tx_er = mac_tx_er;
            next_txd = mac_txd;
        end
    end

    // Register access; read of status clears flags, new events win
    assign csr_rd = reg_read && reg_addr == `MLP_ADDR_CSR;
    always_comb begin
        next_enable = tx_lowpower_enable;
        next_link = phy_link_status;
        next_auto = tx_lowpower_auto;
        next_fd = full_duplex;
        next_mii = mii_mode;
        next_twt = wake_time_value;
        next_ls_limit = ls_limit;
        next_flags = (csr_rd ? 4'h0 : flags) | ev;
        next_rdata = 32'h0000_0000;
        if (reg_write) begin
            case (reg_addr)
                `MLP_ADDR_CSR: begin
                    next_enable = reg_wdata[`MLP_BIT_LP_ENABLE];
                    next_link = reg_wdata[`MLP_BIT_LINK];
                    next_auto = reg_wdata[`MLP_BIT_AUTO];
                end
                `MLP_ADDR_TIMERS: begin
                    next_twt = reg_wdata[`MLP_TW_MSB:`MLP_TW_LSB];
                    next_ls_limit = reg_wdata[`MLP_LS_MSB:`MLP_LS_LSB];
                end
                `MLP_ADDR_CFG: begin
                    next_fd = reg_wdata[`MLP_BIT_FULL_DUPLEX];
                    next_mii = reg_wdata[`MLP_BIT_MII_MODE];
                end
                default: ;
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                `MLP_ADDR_CSR: begin
                    next_rdata[`MLP_BIT_RX_EXIT:`MLP_BIT_TX_ENTRY] = flags;
                    next_rdata[`MLP_BIT_TX_STATE] = tx_state == mlp_tx_lpi;
                    next_rdata[`MLP_BIT_RX_STATE] = rx_lpi;
                    next_rdata[`MLP_BIT_LP_ENABLE] = tx_lowpower_enable;
                    next_rdata[`MLP_BIT_LINK] = phy_link_status;
                    next_rdata[`MLP_BIT_AUTO] = tx_lowpower_auto;
                end
                `MLP_ADDR_TIMERS: begin
                    next_rdata[`MLP_TW_MSB:`MLP_TW_LSB] = wake_time_value;
                    next_rdata[`MLP_LS_MSB:`MLP_LS_LSB] = ls_limit;
                end
                `MLP_ADDR_CFG: begin
                    next_rdata[`MLP_BIT_FULL_DUPLEX] = full_duplex;
                    next_rdata[`MLP_BIT_MII_MODE] = mii_mode;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tx_state <= mlp_tx_norm;
            rx_lpi <= 1'b0;
            rxc_q <= 1'b0;
            us_div <= 5'h0;
            ms_div <= 10'h0;
            link_up_timer <= '0;
            wake_timer <= '0;
            tx_en <= 1'b0;
            tx_er <= 1'b0;
            txd <= `MLP_IDLE_CODE;
            lowpower_irq_out <= 1'b0;
            tx_lowpower_enable <= 1'b0;
            phy_link_status <= 1'b0;
            tx_lowpower_auto <= 1'b0;
            full_duplex <= 1'b0;
            mii_mode <= 1'b0;
            wake_time_value <= `MLP_TW_RESET;
            ls_limit <= `MLP_LS_RESET;
            flags <= 4'h0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            tx_state <= next_tx_state;
            rx_lpi <= next_rx_lpi;
            rxc_q <= next_rxc_q;
            us_div <= next_us_div;
            ms_div <= next_ms_div;
            link_up_timer <= next_link_up_timer;
            wake_timer <= next_wake_timer;
            tx_en <= next_tx_en;
            tx_er <= next_tx_er;
            txd <= next_txd;
            lowpower_irq_out <= next_lp_irq;
            tx_lowpower_enable <= next_enable;
            phy_link_status <= next_link;
            tx_lowpower_auto <= next_auto;
            full_duplex <= next_fd;
            mii_mode <= next_mii;
            wake_time_value <= next_twt;
            ls_limit <= next_ls_limit;
            flags <= next_flags;
            reg_rdata <= next_rdata;
        end
    end

    // Hold-off tells the frame source to wait while idle pattern or wake runs
    assign mac_tx_hold = tx_state != mlp_tx_norm || (tx_lowpower_enable && allowed && link_ok);
    assign irq = |flags;

    a_entry_flag: assert property (@(posedge clock) disable iff (srst)
        tx_state == mlp_tx_norm && next_tx_state == mlp_tx_lpi |=> flags[`MLP_BIT_TX_ENTRY])
        else $error("entry flag not set");
    a_lpi_pattern: assert property (@(posedge clock) disable iff (srst)
        tx_state == mlp_tx_lpi |=> !tx_en && tx_er && txd == `MLP_LPI_CODE)
        else $error("bad low-power pattern");
    a_lpi_hold: assert property (@(posedge clock) disable iff (srst)
        tx_state == mlp_tx_lpi && $past(tx_state == mlp_tx_lpi) |=> $stable(txd) && tx_er)
        else $error("pattern changed");
    a_mode_gate: assert property (@(posedge clock) disable iff (srst)
        tx_state == mlp_tx_norm && !(full_duplex && mii_mode) |=> tx_state != mlp_tx_lpi)
        else $error("entry outside full duplex");
    a_link_gate: assert property (@(posedge clock) disable iff (srst)
        !phy_link_status |=> link_up_timer == '0)
        else $error("link timer not cleared");
    a_exit_flag: assert property (@(posedge clock) disable iff (srst)
        tx_state == mlp_tx_lpi && !tx_lowpower_enable |=> tx_state == mlp_tx_wake ##0 flags[`MLP_BIT_TX_EXIT])
        else $error("exit not flagged");
    a_wake_idle: assert property (@(posedge clock) disable iff (srst)
        tx_state == mlp_tx_wake |-> mac_tx_hold ##1 !tx_en)
        else $error("transmit during wake");
    a_rx_entry: assert property (@(posedge clock) disable iff (srst)
        rx_pat && !rx_lpi |=> flags[`MLP_BIT_RX_ENTRY] && irq)
        else $error("rx entry not flagged");
    a_rx_exit_irq: assert property (@(posedge clock) disable iff (srst)
        !rx_pat && rx_lpi |=> lowpower_irq_out && flags[`MLP_BIT_RX_EXIT])
        else $error("rx exit not signalled");
endmodule : mlp_lpi_ctrl
`default_nettype wire

// ---- logic/mlp_defines.svh ----
`ifndef MLP_DEFINES_SVH
`define MLP_DEFINES_SVH
// Register byte addresses
`define MLP_ADDR_CSR 8'h00
`define MLP_ADDR_TIMERS 8'h04
`define MLP_ADDR_CFG 8'h08
// Control and status fields
`define MLP_BIT_TX_ENTRY 0
`define MLP_BIT_TX_EXIT 1
`define MLP_BIT_RX_ENTRY 2
`define MLP_BIT_RX_EXIT 3
`define MLP_BIT_TX_STATE 8
`define MLP_BIT_RX_STATE 9
`define MLP_BIT_LP_ENABLE 16
`define MLP_BIT_LINK 17
`define MLP_BIT_AUTO 19
// Timers register fields
`define MLP_TW_LSB 0
`define MLP_TW_MSB 15
`define MLP_LS_LSB 16
`define MLP_LS_MSB 25
// Configuration fields
`define MLP_BIT_FULL_DUPLEX 0
`define MLP_BIT_MII_MODE 1
// Reset values
`define MLP_TW_RESET 16'h0000
`define MLP_LS_RESET 10'h3E8
// Line encodings
`define MLP_LPI_CODE 4'h1
`define MLP_IDLE_CODE 4'h0
// Tick units in ns, microseconds per millisecond and clock cycles
`define MLP_CLK_PERIOD_NS 50
`define MLP_US_NS 1000
`define MLP_MS_US 1000
`define MLP_US_CYCLES (`MLP_US_NS / `MLP_CLK_PERIOD_NS)
`endif

// ---- logic/mlp_pkg.sv ----
`default_nettype none
package mlp_pkg;
    typedef enum logic [1:0] {
        mlp_tx_norm,
        mlp_tx_lpi,
        mlp_tx_wake
    } mlp_tx_state_t;
endpackage : mlp_pkg
`default_nettype wire

// ---- logic/mlp_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module mlp_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (srst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
        end
    end
    assign dout = stage2;
endmodule : mlp_sync2
`default_nettype wire

// ---- sim/mlp_phy_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mlp_phy_model (
    input wire logic lpi_req,
    input wire logic may_stop,
    output logic rx_clk,
    output logic rx_dv,
    output logic rx_er,
    output logic [3:0] rxd
);
    int held = 0;
    initial begin
        rx_clk = 1'b0;
        rx_dv = 1'b0;
        rx_er = 1'b0;
        rxd = 4'h0;
    end
    // Clock may only halt well into the low-power period, never at its start
    always #200 if (!(may_stop && lpi_req && held > 9)) rx_clk = ~rx_clk;
    always @(posedge rx_clk) begin
        rx_er <= lpi_req;
        rx_dv <= 1'b0;
        // Idle nibble toggles so a stale value never looks valid
        rxd <= lpi_req ? 4'h1 : ~rxd;
        held <= lpi_req ? held + 1 : 0;
    end
endmodule : mlp_phy_model
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mlp_defines.svh"
module testbench;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic mac_tx_en = 1'b0;
    logic mac_tx_er = 1'b0;
    logic [3:0] mac_txd = 4'h0;
    logic lpi_req = 1'b0;
    logic may_stop = 1'b0;
    logic rx_clk, rx_dv, rx_er, mac_tx_hold, tx_en, tx_er, irq, lowpower_irq_out;
    logic [3:0] rxd, txd;
    logic [31:0] reg_rdata, d;
    logic [31:0] seed = 32'h0000_8363;
    logic [15:0] tw;
    int failures = 0;
    int compares = 0;
    int n;
    localparam logic [31:0] ENA = 32'h0000_0001 << `MLP_BIT_LP_ENABLE;
    localparam logic [31:0] LNK = 32'h0000_0001 << `MLP_BIT_LINK;
    localparam logic [31:0] AUTO = 32'h0000_0001 << `MLP_BIT_AUTO;
    always #25 clock = ~clock;
    mlp_lpi_ctrl u_dut (.clock, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .mac_tx_en, .mac_tx_er, .mac_txd, .mac_tx_hold, .rx_clk, .rx_dv, .rx_er, .rxd,
        .tx_en, .tx_er, .txd, .irq, .lowpower_irq_out);
    mlp_phy_model u_phy (.lpi_req, .may_stop, .rx_clk, .rx_dv, .rx_er, .rxd);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [5:0] lpi_line();
        return {1'b0, 1'b1, `MLP_LPI_CODE};
    endfunction : lpi_line
    // Tick divider restarts at wake entry; the bound allows two extra microseconds and four cycles
    function automatic int wake_max(input logic [15:0] t);
        return (t + 2) * `MLP_US_CYCLES + 4;
    endfunction : wake_max
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic do_reset();
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
    endtask : do_reset
    task automatic wrap_up();
        $display("counts: compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd(`MLP_ADDR_TIMERS);
        chk(d, {6'h00, `MLP_LS_RESET, `MLP_TW_RESET});
        cyc(1);
        chk(reg_rdata, 32'h0000_0000);
        rd(`MLP_ADDR_CSR);
        chk(d, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40);
        chk(d, 32'h0000_0000);
        wr(`MLP_ADDR_CSR, AUTO);
        rd(`MLP_ADDR_CSR);
        chk(d, AUTO);
        wr(`MLP_ADDR_CSR, 32'h0000_0000);
        $display("test reset_values done");
        repeat (16) begin
            @(posedge clock);
            {mac_tx_en, mac_tx_er, mac_txd} <= 6'(rnd());
            cyc(1);
            chk({tx_en, tx_er, txd}, {mac_tx_en, mac_tx_er, mac_txd});
        end
        @(posedge clock);
        {mac_tx_en, mac_tx_er, mac_txd} <= 6'h00;
        wr(`MLP_ADDR_TIMERS, 32'h0000_0000);
        wr(`MLP_ADDR_CFG, 32'h0000_0001);
        wr(`MLP_ADDR_CSR, ENA | LNK);
        cyc(10);
        chk(tx_er, 1'b0);
        @(posedge clock);
        mac_tx_en <= 1'b1;
        wr(`MLP_ADDR_CFG, 32'h0000_0003);
        cyc(6);
        chk({tx_en, tx_er, mac_tx_hold}, 3'b101);
        @(posedge clock);
        mac_tx_en <= 1'b0;
        $display("test duplex_gate done");
        repeat (3) begin
            tw = 16'(rnd() % 4) + 16'h0001;
            wr(`MLP_ADDR_TIMERS, {16'h0000, tw});
            wr(`MLP_ADDR_CSR, ENA | LNK);
            cyc(4);
            chk(irq, 1'b1);
            for (n = 0; n < 8; n++) begin
                chk({tx_en, tx_er, txd}, lpi_line());
                cyc(1);
            end
            rd(`MLP_ADDR_CSR);
            chk(d & 32'h0003_010F, ENA | LNK | 32'h0000_0101);
            wr(`MLP_ADDR_CSR, LNK);
            cyc(3);
            chk({tx_en, tx_er, txd}, {2'b00, `MLP_IDLE_CODE});
            n = 3;
            while (mac_tx_hold === 1'b1 && n < 400) begin
                cyc(1);
                n++;
            end
            chk(n >= tw * `MLP_US_CYCLES && n <= wake_max(tw), 1'b1);
            rd(`MLP_ADDR_CSR);
            chk(d & 32'h0002_000F, LNK | 32'h0000_0002);
        end
        $display("test tx_lowpower done");
        wr(`MLP_ADDR_CSR, ENA | LNK);
        cyc(4);
        chk(tx_er, 1'b1);
        wr(`MLP_ADDR_CSR, ENA);
        cyc(4);
        chk(tx_er, 1'b0);
        wr(`MLP_ADDR_TIMERS, 32'h0001_0001);
        wr(`MLP_ADDR_CSR, ENA | LNK);
        cyc(100);
        chk(tx_er, 1'b0);
        cyc(40 * `MLP_MS_US);
        chk(tx_er, 1'b1);
        do_reset();
        cyc(2);
        chk(tx_er, 1'b0);
        rd(`MLP_ADDR_CSR);
        chk(d, 32'h0000_0000);
        wr(`MLP_ADDR_CFG, 32'h0000_0003);
        $display("test link_timer_reset done");
        @(posedge clock);
        lpi_req <= 1'b1;
        may_stop <= 1'b1;
        cyc(24);
        chk(irq, 1'b1);
        cyc(200);
        rd(`MLP_ADDR_CSR);
        chk(d & 32'h0000_020F, 32'h0000_0204);
        @(posedge clock);
        may_stop <= 1'b0;
        do_reset();
        cyc(8);
        wr(`MLP_ADDR_CFG, 32'h0000_0003);
        cyc(40);
        rd(`MLP_ADDR_CSR);
        chk(d & 32'h0000_0200, 32'h0000_0200);
        @(posedge clock);
        lpi_req <= 1'b0;
        n = 0;
        while (lowpower_irq_out !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(lowpower_irq_out, 1'b1);
        rd(`MLP_ADDR_CSR);
        chk(d & 32'h0000_020F, 32'h0000_0008);
        $display("test rx_lowpower done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
